// ==== sim/ast_rx_model.sv ====
// Far-end receiver model that decodes frames from the serial line by run lengths.
`timescale 1ns/1ps
module ast_rx_model #(
    parameter int P = 16 // Bit period in clock cycles.
) (
    input wire logic mclk,
    input wire logic line,
    input wire logic listen,
    input wire logic nine,
    output logic [8:0] rx_data,
    output logic rx_valid,
    output logic rx_err
);
    logic [10:0] bits; // Start, data and stop as decoded.
    logic lvl;
    int nb, len, tot, k, cap;
    initial begin
        rx_valid = 1'b0;
        rx_err = 1'b0;
        rx_data = 9'h000;
    end
    // Each run is rounded down to whole bit periods; a run that is not a whole number of periods flags an error.
    always begin
        @(posedge mclk);
        rx_valid <= 1'b0;
        if (listen === 1'b1 && line === 1'b0) begin
            tot = nine ? 11 : 10;
            nb = 0;
            rx_err <= 1'b0;
            while (nb < tot) begin
                lvl = line;
                cap = (tot - nb) * P;
                len = 0;
                while (line === lvl && len < cap) begin
                    len++;
                    // The frame's last edge is not passed, so a following start is seen whole.
                    if (len < cap) @(posedge mclk);
                end
                k = len / P;
                if (len < cap && len % P != 0) rx_err <= 1'b1;
                if (len >= cap) k = tot - nb;
                for (int j = 0; j < k; j++) bits[nb + j] = lvl;
                nb += k;
            end
            if (bits[0] !== 1'b0 || bits[tot - 1] !== 1'b1) rx_err <= 1'b1;
            rx_data <= nine ? bits[9:1] : {1'b0, bits[8:1]};
            rx_valid <= 1'b1;
        end
    end
endmodule

// ==== sim/ast_tx_props.sv ====
// Port-level assertions for the serial transmitter, bound to its top module.
`timescale 1ns/1ps
`include "ast_defs.svh"
module ast_tx_props (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic transmit_pin_out,
    input wire logic transmit_pin_oe,
    input wire logic tx_irq_request
);
    logic [7:0] txc, rxc, bcc, irc, dlo; // Shadows of what software last wrote.
    logic [1:0] cfg, cfg_d, cfg_dd; // Invert and enable, plus two delayed copies.
    logic wr, rd, en, stab;
    assign wr = psel && penable && pwrite && pready;
    assign rd = psel && penable && !pwrite;
    assign en = rxc[7] && txc[5] && !txc[4];
    assign cfg = {bcc[4], en};
    // Pins are only judged once the settings have been still for a while.
    assign stab = (cfg == cfg_d) && (cfg_d == cfg_dd);
    // Follow register writes so the pins can be judged against them.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            {txc, rxc, bcc, irc, dlo} <= '0;
        end else if (wr) begin
            case (paddr)
                `AST_OFF_TX_CONTROL_STATUS: txc <= pwdata[7:0];
                `AST_OFF_RX_CONTROL_STATUS: rxc <= pwdata[7:0];
                `AST_OFF_BAUD_CONTROL: bcc <= pwdata[7:0];
                `AST_OFF_IRQ_CONTROL: irc <= pwdata[7:0];
                `AST_OFF_DIVISOR_LOW: dlo <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    // Delay line for the settings, cleared with the block.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_d <= 2'h0;
            cfg_dd <= 2'h0;
        end else begin
            cfg_d <= cfg;
            cfg_dd <= cfg_d;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    oe_follows_cfg_a: assert property (stab |-> transmit_pin_oe == en)
        else $error("pin enable disagrees with the port settings");
    idle_mark_a: assert property (stab && !en |-> transmit_pin_out == !bcc[4])
        else $error("disabled line is not at its idle level");
    irq_gate_a: assert property (tx_irq_request
        |-> $past(irc[2:0]) == 3'h7 && $past(txc[5]))
        else $error("interrupt request without all its enables");
    reset_idle_a: assert property ($rose(rst_n)
        |-> transmit_pin_out && !transmit_pin_oe && !tx_irq_request)
        else $error("outputs not idle after reset");
    flag_off_a: assert property (rd && paddr == `AST_OFF_FLAG_STATUS
        && !$past(txc[5], 2) |-> !prdata[0])
        else $error("free flag set with transmitter off");
    shifter_idle_a: assert property (rd && paddr == `AST_OFF_TX_CONTROL_STATUS
        && stab && !en |-> prdata[1])
        else $error("shifter not empty while disabled");
    divlo_read_a: assert property (rd && paddr == `AST_OFF_DIVISOR_LOW
        |-> prdata == {24'h000000, dlo})
        else $error("divisor low reads back wrong");
    no_error_a: assert property (pready && !pslverr)
        else $error("bus answer not ready or in error");
    cover property ($rose(tx_irq_request));
    cover property ($rose(transmit_pin_oe));
    cover property (en && $fell(transmit_pin_out ^ bcc[4]));
endmodule
bind ast_tx ast_tx_props props (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .transmit_pin_out, .transmit_pin_oe, .tx_irq_request);

// ==== sim/ast_tx_tb.sv ====
// Self-checking bench for the serial transmitter with a far-end receiver.
`timescale 1ns/1ps
`include "ast_defs.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
    $display("Error %s expected %h seen %h", nm, ex, got); num_errors++; end end
module ast_tx_tb;
    logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv, rv;
    logic pready, pslverr, pin_out, pin_oe, irq, rx_valid, rx_err;
    logic inv = 1'b0, listen = 1'b0, nine = 1'b0, line;
    logic [8:0] rx_data, q;
    logic [8:0] exp_q[$]; // Characters noted by the driver, oldest first.
    logic [7:0] txc = 8'h24; // Transmit on with the high-speed prescale bit.
    int num_errors = 0, comparisons = 0, seed = 8, i, n;
    // A released pin is pulled up; the receiver sees the line with inversion undone.
    assign line = (pin_oe ? pin_out : 1'b1) ^ inv;
    always #5 mclk = ~mclk;
    ast_tx dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .transmit_pin_out(pin_out), .transmit_pin_oe(pin_oe), .tx_irq_request(irq));
    ast_rx_model #(.P(16)) far (.mclk(mclk), .line(line), .listen(listen), .nine(nine),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_err(rx_err));
    // One APB transfer; the edge at the start keeps psel from being set twice at once.
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic [31:0] m);
        apb(a, 1'b0, 32'h0);
        `CHK($sformatf("reg %h", a), ex & m, rdv & m)
    endtask
    // Waits for a free buffer, then in nine-bit mode writes the ninth bit ahead of the data.
    task automatic send(input logic [8:0] d);
        n = 0;
        do begin
            apb(`AST_OFF_FLAG_STATUS, 1'b0, 32'h0);
            n++;
        end while (rdv[0] !== 1'b1 && n < 300);
        if (nine) apb(`AST_OFF_TX_CONTROL_STATUS, 1'b1, {24'h0, txc | {7'h0, d[8]}});
        exp_q.push_back(nine ? d : {1'b0, d[7:0]});
        apb(`AST_OFF_TRANSMIT_BUFFER, 1'b1, {24'h0, d[7:0]});
    endtask
    task automatic drain();
        n = 0;
        while (exp_q.size() != 0 && n < 4000) begin
            @(posedge mclk);
            n++;
        end
        `CHK("frames pending", 32'd0, exp_q.size())
        repeat (40) @(posedge mclk);
    endtask
    task automatic summarize();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Each decoded frame is matched against the oldest noted character.
    always @(posedge mclk) begin
        if (rx_valid === 1'b1) begin
            `CHK("frame present", 1'b1, exp_q.size() != 0)
            q = (exp_q.size() != 0) ? exp_q.pop_front() : 9'h1FF;
            `CHK("frame data", q, rx_data)
            `CHK("frame shape", 1'b0, rx_err)
        end
    end
    initial begin
        #600000;
        num_errors++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        apb(`AST_OFF_TX_CONTROL_STATUS, 1'b1, 32'h0);
        rd(`AST_OFF_TX_CONTROL_STATUS, 32'h2, 32'h22);
        apb(`AST_OFF_FLAG_STATUS, 1'b1, 32'h1);
        rd(`AST_OFF_FLAG_STATUS, 32'h0, 32'h1);
        apb(12'h020, 1'b1, 32'hFF);
        rd(12'h020, 32'h0, 32'hFFFFFFFF);
        `CHK("pin enable", 1'b0, pin_oe)
        `CHK("pin level", 1'b1, pin_out)
        $display("test reset done");
        apb(`AST_OFF_DIVISOR_LOW, 1'b1, 32'h0);
        apb(`AST_OFF_DIVISOR_HIGH, 1'b1, 32'h12);
        apb(`AST_OFF_BAUD_CONTROL, 1'b1, 32'h0);
        apb(`AST_OFF_RX_CONTROL_STATUS, 1'b1, 32'h80);
        apb(`AST_OFF_TX_CONTROL_STATUS, 1'b1, {24'h0, txc});
        rd(`AST_OFF_FLAG_STATUS, 32'h1, 32'h1);
        `CHK("pin enable", 1'b1, pin_oe)
        apb(`AST_OFF_TX_CONTROL_STATUS, 1'b1, 32'h34);
        repeat (2) @(posedge mclk);
        `CHK("clocked mode", 1'b0, pin_oe)
        apb(`AST_OFF_TX_CONTROL_STATUS, 1'b1, {24'h0, txc});
        apb(`AST_OFF_IRQ_CONTROL, 1'b1, 32'h7);
        repeat (3) @(posedge mclk);
        `CHK("irq on", 1'b1, irq)
        apb(`AST_OFF_IRQ_CONTROL, 1'b1, 32'h3);
        repeat (3) @(posedge mclk);
        `CHK("irq gated", 1'b0, irq)
        $display("test setup done");
        listen <= 1'b1;
        rv = $random(seed);
        send({1'b0, rv[7:0]});
        send({1'b0, rv[15:8]});
        repeat (2) @(posedge mclk);
        rd(`AST_OFF_FLAG_STATUS, 32'h0, 32'h1);
        rd(`AST_OFF_TX_CONTROL_STATUS, 32'h0, 32'h2);
        for (i = 0; i < 5; i++) begin
            rv = $random(seed);
            send({1'b0, i == 0 ? 8'h00 : i == 1 ? 8'hFF : rv[7:0]});
        end
        drain();
        $display("test eight bit divider done");
        apb(`AST_OFF_DIVISOR_HIGH, 1'b1, 32'h0);
        apb(`AST_OFF_DIVISOR_LOW, 1'b1, 32'h3);
        rd(`AST_OFF_DIVISOR_LOW, 32'h3, 32'hFF);
        apb(`AST_OFF_BAUD_CONTROL, 1'b1, 32'h8);
        for (i = 0; i < 2; i++) begin
            rv = $random(seed);
            send({1'b0, rv[7:0]});
        end
        drain();
        $display("test wide divider done");
        nine <= 1'b1;
        txc = 8'h64;
        for (i = 0; i < 3; i++) begin
            rv = $random(seed);
            send({i[0], rv[7:0]});
        end
        drain();
        nine <= 1'b0;
        txc = 8'h24;
        apb(`AST_OFF_TX_CONTROL_STATUS, 1'b1, {24'h0, txc});
        $display("test nine bit done");
        listen <= 1'b0;
        apb(`AST_OFF_BAUD_CONTROL, 1'b1, 32'h18);
        repeat (4) @(posedge mclk);
        `CHK("inverted idle", 1'b0, pin_out)
        inv <= 1'b1;
        repeat (2) @(posedge mclk);
        listen <= 1'b1;
        rv = $random(seed);
        send({1'b0, rv[7:0]});
        drain();
        listen <= 1'b0;
        apb(`AST_OFF_BAUD_CONTROL, 1'b1, 32'h8);
        inv <= 1'b0;
        $display("test invert done");
        apb(`AST_OFF_TRANSMIT_BUFFER, 1'b1, 32'hA5);
        repeat (40) @(posedge mclk);
        apb(`AST_OFF_RX_CONTROL_STATUS, 1'b1, 32'h0);
        repeat (4) @(posedge mclk);
        `CHK("released pin", 1'b0, pin_oe)
        `CHK("aborted line", 1'b1, pin_out)
        rd(`AST_OFF_TX_CONTROL_STATUS, 32'h2, 32'h2);
        apb(`AST_OFF_RX_CONTROL_STATUS, 1'b1, 32'h80);
        rd(`AST_OFF_FLAG_STATUS, 32'h1, 32'h1);
        listen <= 1'b1;
        send(9'h03C);
        drain();
        $display("test port off done");
        summarize();
    end
endmodule

// ==== verilog/ast_baud_gen.sv ====
// Baud generator: divides the system clock into one tick per bit period.
`timescale 1ns/1ps
`include "ast_defs.svh"
module ast_baud_gen (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic wide_divider,
    input wire logic high_speed_divider,
    input wire logic [15:0] divisor,
    output logic bit_tick
);
    // Prescaler count between divisor steps and divisor count itself.
    logic [5:0] pre_count;
    logic [1:0] pre_sel;
    logic [15:0] div_count;
    logic pre_tick;
    logic [15:0] reload;

    // Prescale of 4, 16 or 64 set by the two speed bits.
    always_comb begin
        if (wide_divider && high_speed_divider) begin
            pre_sel = `AST_DIV_BY_FOUR;
        end else if (wide_divider || high_speed_divider) begin
            pre_sel = `AST_DIV_BY_SIXTEEN;
        end else begin
            pre_sel = `AST_DIV_BY_SIXTYFOUR;
        end
    end

    // The prescaler tick fires at the last count of the selected range.
    assign pre_tick = (pre_count[1:0] == 2'h3) &&
        ((pre_sel == `AST_DIV_BY_FOUR) ||
         (pre_sel == `AST_DIV_BY_SIXTEEN && pre_count[3:2] == 2'h3) ||
         (pre_count[5:2] == 4'hF));

    // In 8-bit mode only the low divisor byte counts.
    assign reload = wide_divider ? divisor : {8'h00, divisor[7:0]};

    // Prescaler runs freely while the port is active; stopping it restarts bit timing.
    always_ff @(posedge mclk) begin
        if (!rst_n || !run) begin
            pre_count <= 6'h00;
        end else if (pre_tick) begin
            pre_count <= 6'h00;
        end else begin
            pre_count <= pre_count + 6'h01;
        end
    end

    // Divisor counter: period is (divisor+1) prescaled steps. RULE_05 RULE_23
    always_ff @(posedge mclk) begin
        if (!rst_n || !run) begin
            div_count <= `AST_RST_COUNT;
            bit_tick <= 1'b0;
        end else begin
            bit_tick <= 1'b0;
            if (pre_tick) begin
                if (div_count >= reload) begin
                    div_count <= `AST_RST_COUNT;
                    bit_tick <= 1'b1;
                end else begin
                    div_count <= div_count + `AST_ONE_COUNT;
                end
            end
        end
    end
endmodule

// ==== verilog/ast_defs.svh ====
// Register offsets, field positions and reset values for the serial transmitter.
`ifndef AST_DEFS_SVH
`define AST_DEFS_SVH
`define AST_OFF_BAUD_CONTROL 12'h000
`define AST_OFF_RX_CONTROL_STATUS 12'h004
`define AST_OFF_DIVISOR_LOW 12'h008
`define AST_OFF_DIVISOR_HIGH 12'h00C
`define AST_OFF_TRANSMIT_BUFFER 12'h010
`define AST_OFF_TX_CONTROL_STATUS 12'h014
`define AST_OFF_IRQ_CONTROL 12'h018
`define AST_OFF_FLAG_STATUS 12'h01C
// Field positions in tx_control_status.
`define AST_TXS_NINE_BIT 6
`define AST_TXS_TRANSMIT_ON 5
`define AST_TXS_CLOCKED 4
`define AST_TXS_HIGH_SPEED 2
`define AST_TXS_SHIFTER_EMPTY 1
`define AST_TXS_NINTH_BIT 0
// Field positions in rx_control_status and baud_control.
`define AST_RXS_PORT_ON 7
`define AST_BC_TX_INVERT 4
`define AST_BC_WIDE 3
// Field positions in irq_control and flag_status.
`define AST_IRQ_TX_ON 0
`define AST_IRQ_PERIPH_ON 1
`define AST_IRQ_GLOBAL_ON 2
`define AST_FLAG_BUF_FREE 0
// Masks of the bits that software may write.
`define AST_TXS_WR_MASK 8'h75
`define AST_RXS_WR_MASK 8'h80
`define AST_BC_WR_MASK 8'h18
`define AST_IRQ_WR_MASK 8'h07
// Reset values.
`define AST_RST_BYTE 8'h00
`define AST_RST_WORD 32'h0000_0000
`define AST_RST_COUNT 16'h0000
`define AST_RST_BITS 4'h0
`define AST_RST_SHIFT 10'h000
// Frame shape: start plus nine data plus stop at most.
`define AST_BITS_EIGHT 4'h9
`define AST_BITS_NINE 4'hA
`define AST_ONE_BIT 4'h1
`define AST_ONE_COUNT 16'h0001
`define AST_DIV_BY_FOUR 2'h0
`define AST_DIV_BY_SIXTEEN 2'h2
`define AST_DIV_BY_SIXTYFOUR 2'h3
`endif

// ==== verilog/ast_pkg.sv ====
// Types shared by the serial transmitter files.
package ast_pkg;
    // Transmitter sequence states, one-hot.
    typedef enum logic [2:0] {
        AST_IDLE = 3'b001,
        AST_SEND = 3'b010,
        AST_LOAD = 3'b100
    } ast_state_t;
endpackage

// ==== verilog/ast_tx.sv ====
// Asynchronous serial transmitter with APB register access.
// Behaviour
// RULE_01 - Idle line held at mark level.
// RULE_02 - Frame: start, eight/nine data, stop.
// RULE_03 - Start bit space, stop bit mark.
// RULE_04 - Each bit lasts one baud period.
// RULE_05 - Baud generator divides clock, 8/16 bit.
// RULE_06 - Data bits sent LSB first.
// RULE_07 - Shared format and rate, no parity.
// RULE_08 - Active when transmit_on, async, port_on.
// RULE_09 - Port on forces transmit pin output.
// RULE_10 - Disabled section releases its pin.
// RULE_11 - Transmit_on sets buffer-free flag.
// RULE_12 - Buffer write starts; empty shifter loads immediately.
// RULE_13 - Busy shifter: load after stop bit.
// RULE_14 - Invert flips idle level and data.
// RULE_15 - Flag clear only when busy and queued.
// RULE_16 - Flag valid from second cycle after write.
// RULE_17 - Flag read-only, independent of irq enable.
// RULE_18 - Shifter_empty clears on load, no interrupt.
// RULE_19 - Nine-bit mode sends ninth bit as MSB.
// RULE_20 - Software writes ninth bit before data.
// RULE_21 - Software follows configuration order.
// RULE_22 - Irq on with flag set requests at once.
// RULE_23 - Divisor registers set tick; port off resets.
`timescale 1ns/1ps
`include "ast_defs.svh"
module ast_tx (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic transmit_pin_out,
    output logic transmit_pin_oe,
    output logic tx_irq_request
);
    import ast_pkg::*;

    // Software registers.
    logic [7:0] baud_control; // Invert and wide divider bits.
    logic [7:0] rx_control_status; // Only the port-on bit lives here.
    logic [7:0] divisor_low; // Low byte of the bit divisor.
    logic [7:0] divisor_high; // High byte of the bit divisor.
    logic [7:0] transmit_buffer; // One-deep holding buffer.
    logic [7:0] tx_control_status; // Control bits; shifter_empty is merged on read.
    logic [7:0] irq_control; // Interrupt enables for the transmit request.

    // Transmit datapath.
    ast_state_t state; // Sequence state.
    ast_state_t next_state; // Its next value.
    logic [9:0] transmit_shifter; // Start, data and ninth bit, shifted right.
    logic [3:0] bits_left; // Bits still to send after the current one.
    logic buffer_full; // A character is waiting in the buffer.
    logic buffer_free_flag; // Registered view of the free flag.
    logic line_level; // True-polarity line value.
    logic bit_tick; // One pulse per bit period.

    // Decoded controls.
    logic port_on;
    logic transmit_on;
    logic clocked_mode;
    logic tx_active;
    logic nine_bit_tx;
    logic tx_invert;
    logic shifter_empty;
    logic apb_write;
    logic buffer_write;

    assign port_on = rx_control_status[`AST_RXS_PORT_ON];
    assign transmit_on = tx_control_status[`AST_TXS_TRANSMIT_ON];
    assign clocked_mode = tx_control_status[`AST_TXS_CLOCKED];
    // Only asynchronous mode is built, so a set clocked bit simply keeps us quiet.
    assign tx_active = transmit_on && !clocked_mode && port_on; // RULE_08
    assign nine_bit_tx = tx_control_status[`AST_TXS_NINE_BIT];
    assign tx_invert = baud_control[`AST_BC_TX_INVERT];
    assign shifter_empty = (state == AST_IDLE); // RULE_18
    assign apb_write = psel && penable && pwrite;
    assign buffer_write = apb_write && (paddr == `AST_OFF_TRANSMIT_BUFFER);

    // The slave always answers in the first access cycle and never errors.
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // Bit timing shares one generator, as a receiver would too. RULE_07
    ast_baud_gen u_baud (
        .mclk(mclk),
        .rst_n(rst_n),
        // Restarting it as a character leaves idle gives the start bit a full period. RULE_04
        .run(port_on && !(state == AST_IDLE && buffer_full)),
        .wide_divider(baud_control[`AST_BC_WIDE]),
        .high_speed_divider(tx_control_status[`AST_TXS_HIGH_SPEED]),
        .divisor({divisor_high, divisor_low}),
        .bit_tick(bit_tick)
    );

    // Control register writes; read-only bits are masked out.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            baud_control <= `AST_RST_BYTE;
            rx_control_status <= `AST_RST_BYTE;
            divisor_low <= `AST_RST_BYTE;
            divisor_high <= `AST_RST_BYTE;
            tx_control_status <= `AST_RST_BYTE;
            irq_control <= `AST_RST_BYTE;
        end else if (apb_write) begin
            case (paddr)
                `AST_OFF_BAUD_CONTROL: begin
                    baud_control <= pwdata[7:0] & `AST_BC_WR_MASK;
                end
                `AST_OFF_RX_CONTROL_STATUS: begin
                    rx_control_status <= pwdata[7:0] & `AST_RXS_WR_MASK;
                end
                `AST_OFF_DIVISOR_LOW: begin
                    divisor_low <= pwdata[7:0];
                end
                `AST_OFF_DIVISOR_HIGH: begin
                    divisor_high <= pwdata[7:0];
                end
                `AST_OFF_TX_CONTROL_STATUS: begin
                    // Ninth bit is written here first, then the buffer. RULE_20
                    tx_control_status <= pwdata[7:0] & `AST_TXS_WR_MASK;
                end
                `AST_OFF_IRQ_CONTROL: begin
                    irq_control <= pwdata[7:0] & `AST_IRQ_WR_MASK;
                end
                default: begin
                    // Other offsets hold nothing writable here.
                end
            endcase
        end
    end

    // Holding buffer: written data is kept and readable back.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            transmit_buffer <= `AST_RST_BYTE;
        end else if (buffer_write) begin
            transmit_buffer <= pwdata[7:0];
        end
    end

    // Buffer occupancy: a write fills it, a move into the shifter empties it.
    // Port off or transmit off discards any queued character. RULE_23
    always_ff @(posedge mclk) begin
        if (!rst_n || !tx_active) begin
            buffer_full <= 1'b0;
        end else if (buffer_write) begin
            // A write in the same cycle as a move wins, so no character is lost.
            buffer_full <= 1'b1; // RULE_12
        end else if (state == AST_LOAD) begin
            buffer_full <= 1'b0;
        end
    end

    // Next state of the transmit sequence.
    always_comb begin
        next_state = state;
        case (state)
            AST_IDLE: begin
                // Empty shifter: a buffered character moves over at once. RULE_12
                if (buffer_full) begin
                    next_state = AST_LOAD;
                end
            end
            AST_LOAD: begin
                next_state = AST_SEND;
            end
            AST_SEND: begin
                if (bit_tick && bits_left == `AST_RST_BITS) begin
                    // Stop bit done; a waiting character loads in one cycle. RULE_13
                    next_state = buffer_full ? AST_LOAD : AST_IDLE;
                end
            end
            default: begin
                next_state = AST_IDLE;
            end
        endcase
    end

    // State register; disabling the port or transmitter aborts the frame.
    always_ff @(posedge mclk) begin
        if (!rst_n || !tx_active) begin
            state <= AST_IDLE; // RULE_23
        end else begin
            state <= next_state;
        end
    end

    // Shifter: loading builds the frame, each tick moves one bit out.
    // The divider restarts on a load from idle, so the start bit gets a full period.
    always_ff @(posedge mclk) begin
        if (!rst_n || !tx_active) begin
            transmit_shifter <= `AST_RST_SHIFT;
            bits_left <= `AST_RST_BITS;
            line_level <= 1'b1;
        end else begin
            case (state)
                AST_LOAD: begin
                    // All ten bits move together; start bit goes first. RULE_19 RULE_02
                    transmit_shifter <= {tx_control_status[`AST_TXS_NINTH_BIT],
                        transmit_buffer, 1'b0};
                    bits_left <= nine_bit_tx ? `AST_BITS_NINE : `AST_BITS_EIGHT;
                    line_level <= 1'b0; // RULE_03
                end
                AST_SEND: begin
                    if (bit_tick) begin
                        // Each bit stands one full tick period. RULE_04
                        if (bits_left == `AST_ONE_BIT) begin
                            line_level <= 1'b1; // RULE_03
                        end else if (bits_left == `AST_RST_BITS) begin
                            // A queued start goes out on the stop's closing tick. RULE_13 RULE_04
                            line_level <= !buffer_full;
                        end else begin
                            // LSB first: next data bit is bit 1 before the shift. RULE_06
                            line_level <= transmit_shifter[1];
                        end
                        transmit_shifter <= {1'b1, transmit_shifter[9:1]};
                        if (bits_left != `AST_RST_BITS) begin
                            bits_left <= bits_left - `AST_ONE_BIT;
                        end
                    end
                end
                default: begin
                    line_level <= 1'b1; // RULE_01
                end
            endcase
        end
    end

    // Free flag: set whenever enabled and nothing queued. Updated one cycle after the
    // write, so it is correct from the second cycle on. RULE_11 RULE_15 RULE_16
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            buffer_free_flag <= 1'b0;
        end else begin
            buffer_free_flag <= tx_active && !buffer_full;
        end
    end

    // Interrupt request follows the flag only when all three enables are set. RULE_22
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_irq_request <= 1'b0;
        end else begin
            tx_irq_request <= buffer_free_flag && irq_control[`AST_IRQ_TX_ON] &&
                irq_control[`AST_IRQ_PERIPH_ON] && irq_control[`AST_IRQ_GLOBAL_ON];
        end
    end

    // Pin drive: port on with transmit on in async mode claims the pin as output, else it is released. RULE_09 RULE_10
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            transmit_pin_oe <= 1'b0;
            transmit_pin_out <= 1'b1;
        end else begin
            transmit_pin_oe <= port_on && transmit_on && !clocked_mode;
            // Invert flips idle and data alike. RULE_14 RULE_01
            transmit_pin_out <= line_level ^ tx_invert;
        end
    end

    // Read data; status bits are merged from live state, flag is read-only. RULE_17
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata <= `AST_RST_WORD;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `AST_OFF_BAUD_CONTROL: prdata <= {24'h000000, baud_control};
                `AST_OFF_RX_CONTROL_STATUS: prdata <= {24'h000000, rx_control_status};
                `AST_OFF_DIVISOR_LOW: prdata <= {24'h000000, divisor_low};
                `AST_OFF_DIVISOR_HIGH: prdata <= {24'h000000, divisor_high};
                `AST_OFF_TRANSMIT_BUFFER: prdata <= {24'h000000, transmit_buffer};
                `AST_OFF_TX_CONTROL_STATUS: begin
                    // Shifter state is reported without any interrupt path. RULE_18
                    prdata <= {24'h000000, tx_control_status[7:2], shifter_empty,
                        tx_control_status[0]};
                end
                `AST_OFF_IRQ_CONTROL: prdata <= {24'h000000, irq_control};
                `AST_OFF_FLAG_STATUS: prdata <= {31'h00000000, buffer_free_flag};
                default: prdata <= `AST_RST_WORD;
            endcase
        end
    end
endmodule
